// file: hw/adsr_pkg.sv
/*
  Package for the converter serial readout and power control block.
  Holds register offsets, field positions, reset values, opcodes and timing counts.
  Assumes a 200 MHz aclk.
*/
package adsr_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int UPDATE_PULSE_CLKS = 4;
  localparam int POR_CYCLES_DEF = 65536;
  localparam int TIMEOUT_PERIODS = 64;
  localparam int MOD_DIV = 4;
  localparam int MOD_SYNC_DELAY = 5;
  localparam int WORD_BITS = 32;
  localparam int CMD_BITS = 8;

  // Register byte offsets
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;

  // Control fields
  localparam int CTRL_FILT_LSB = 0;
  localparam logic [1:0] FILT_MODULATOR = 2'h0;
  localparam logic [1:0] FILT_SINC = 2'h1;
  localparam logic [1:0] FILT_RESET = 2'h2;

  // Status field positions
  localparam int STAT_CONTINUOUS = 0;
  localparam int STAT_STANDBY = 1;
  localparam int STAT_POR_DONE = 2;
  localparam int STAT_CONV_RUN = 3;
  localparam int STAT_READY_N = 4;
  localparam int STAT_READ_PEND = 5;

  // Serial opcodes
  localparam logic [6:0] OP_WAKE_HI = 7'h00;
  localparam logic [6:0] OP_STBY_HI = 7'h01;
  localparam logic [7:0] OP_ENTER_CONT = 8'h10;
  localparam logic [7:0] OP_STOP_CONT = 8'h11;
  localparam logic [7:0] OP_READ_ONE = 8'h12;

  // Mod clock divider phase loaded on sync so the next rise is five clocks on
  localparam logic [2:0] MOD_SYNC_LOAD = 3'h5;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
endpackage : adsr_pkg

// file: hw/adsr_top.sv
/*
  Serial readout and power control for a high resolution converter core.
  Assumes: all pins synchronous to aclk; sclk slower than aclk/2; the converter
  core delivers one formatted-ready value per conversion with conv_valid.
*/
`timescale 1ns/10ps
module adsr_top
  import adsr_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power and supplies
  input wire logic power_down_n,
  input wire logic supplies_ok,
  output logic conv_run,
  // Converter core
  input wire logic conv_valid,
  input wire logic [30:0] conv_value,
  input wire logic conv_clip_pos,
  input wire logic conv_clip_neg,
  input wire logic [1:0] mod_stream,
  // Serial port
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic result_ready_n,
  // Modulator pins
  input wire logic sync_in,
  output logic modulator_bit_low_o,
  output logic modulator_bit_low_oe,
  output logic modulator_bit_high_o,
  output logic modulator_bit_high_oe,
  output logic mod_clk_o,
  output logic mod_clk_oe
);

  typedef struct packed {
    logic [16:0] por_cnt;
    logic por_done;
    logic standby;
    logic continuous;
    logic [1:0] filt;
    logic sclk_prev;
    logic [2:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [5:0] tx_cnt;
    logic [31:0] tx_sh;
    logic dout;
    logic ready_n;
    logic [2:0] upd_cnt;
    logic read_pend;
    logic [6:0] idle_periods;
    logic [31:0] result;
    logic conv_run;
    logic [2:0] mod_phase;
    logic mod_clk;
    logic [1:0] mod_bits;
    logic mod_oe;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adsr_state_t;

  adsr_state_t s_q;
  adsr_state_t s_d;

  logic sclk_rise;
  logic sclk_fall;
  logic [31:0] word;
  logic [7:0] cmd;

  // Result formatting
  always_comb
  begin
    word = {conv_value, conv_value[30]};
    if (s_q.filt == FILT_SINC)
    begin
      word = {conv_value[30], conv_value};
    end
    else if (conv_clip_pos)
    begin
      word = 32'h7FFFFFFF;
    end
    else if (conv_clip_neg)
    begin
      word = 32'h80000000;
    end
  end

  assign sclk_rise = sclk & ~s_q.sclk_prev;
  assign sclk_fall = ~sclk & s_q.sclk_prev;
  assign cmd = {s_q.rx_sh[6:0], din};

  always_comb
  begin
    s_d = s_q;
    s_d.sclk_prev = sclk;

    // Power-on count restarts whenever a supply drops
    if (!supplies_ok)
    begin
      s_d.por_cnt = '0;
      s_d.por_done = 1'b0;
    end
    else if (!s_q.por_done)
    begin
      if (s_q.por_cnt == 17'(POR_CYCLES - 1))
      begin
        s_d.por_done = 1'b1;
      end
      s_d.por_cnt = s_q.por_cnt + 17'h1;
    end

    // Serial receive
    if (sclk_rise)
    begin
      s_d.rx_sh = cmd;
      s_d.rx_cnt = s_q.rx_cnt + 3'h1;
      if (s_q.rx_cnt == 3'(CMD_BITS - 1))
      begin
        if (cmd[7:1] == OP_WAKE_HI)
        begin
          s_d.standby = 1'b0;
        end
        else if (cmd[7:1] == OP_STBY_HI)
        begin
          s_d.standby = 1'b1;
        end
        else if (cmd == OP_ENTER_CONT)
        begin
          s_d.continuous = 1'b1;
        end
        else if (cmd == OP_STOP_CONT)
        begin
          s_d.continuous = 1'b0;
        end
        else if (cmd == OP_READ_ONE && !s_q.continuous)
        begin
          s_d.read_pend = 1'b1;
        end
      end
    end

    // Serial transmit
    if (sclk_fall)
    begin
      s_d.ready_n = 1'b1;
      if (s_q.tx_cnt < 6'(WORD_BITS - 1))
      begin
        s_d.tx_sh = {s_q.tx_sh[30:0], 1'b0};
        s_d.dout = s_q.tx_sh[30];
        s_d.tx_cnt = s_q.tx_cnt + 6'h1;
      end
      else
      begin
        s_d.dout = 1'b0;
        s_d.tx_cnt = 6'(WORD_BITS);
      end
    end

    // Result update, held off four clocks with ready high
    if (conv_valid && s_q.conv_run)
    begin
      s_d.upd_cnt = 3'(UPDATE_PULSE_CLKS);
      s_d.ready_n = 1'b1;
      if (s_q.sclk_prev == 1'b0 && s_q.idle_periods < 7'(TIMEOUT_PERIODS))
      begin
        s_d.idle_periods = s_q.idle_periods + 7'h1;
      end
    end
    else if (s_q.upd_cnt != 3'h0)
    begin
      s_d.upd_cnt = s_q.upd_cnt - 3'h1;
      if (s_q.upd_cnt == 3'h1)
      begin
        s_d.result = word;
        if (s_q.continuous)
        begin
          s_d.ready_n = 1'b0;
          s_d.tx_sh = word;
          s_d.dout = word[31];
          s_d.tx_cnt = '0;
        end
        else if (s_q.read_pend && (s_q.tx_cnt == 6'h0 || s_q.tx_cnt >= 6'(WORD_BITS)))
        begin
          // A read command landing on the load edge stays pending
          s_d.read_pend = sclk_rise && (s_q.rx_cnt == 3'(CMD_BITS - 1)) && (cmd == OP_READ_ONE);
          s_d.tx_sh = word;
          s_d.dout = word[31];
          s_d.tx_cnt = '0;
        end
      end
    end
    if (!s_q.continuous)
    begin
      s_d.ready_n = 1'b1;
    end

    // Serial time-out while sclk stays low
    if (sclk)
    begin
      s_d.idle_periods = '0;
    end
    else if (s_q.idle_periods >= 7'(TIMEOUT_PERIODS))
    begin
      s_d.idle_periods = '0;
      s_d.rx_cnt = '0;
      s_d.rx_sh = '0;
      s_d.tx_cnt = 6'(WORD_BITS);
      s_d.dout = 1'b0;
      s_d.read_pend = 1'b0;
    end

    s_d.conv_run = s_q.por_done & power_down_n & ~s_d.standby;

    // Modulator clock divider
    s_d.mod_phase = (s_q.mod_phase == 3'(MOD_DIV - 1)) ? 3'h0 : s_q.mod_phase + 3'h1;
    if (sync_in)
    begin
      s_d.mod_phase = MOD_SYNC_LOAD;
    end
    s_d.mod_oe = (s_q.filt == FILT_MODULATOR) && s_d.conv_run;
    s_d.mod_clk = s_d.mod_oe && (s_d.mod_phase == 3'h2 || s_d.mod_phase == 3'h3);
    s_d.mod_bits = s_d.mod_oe ? mod_stream : 2'h0;

    // AXI write
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      case (s_q.aw_addr[3:2])
        REG_CONTROL[3:2]:
        begin
          if (s_q.w_strb[0])
          begin
            s_d.filt = s_q.w_data[CTRL_FILT_LSB +: 2];
          end
        end
        REG_STATUS[3:2], REG_RESULT[3:2]:
        begin
          s_d.bresp = AXI_OKAY;
        end
        default:
        begin
          s_d.bresp = AXI_DECERR;
        end
      endcase
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wready = ~s_d.w_got & ~s_d.bvalid;

    // AXI read
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = AXI_OKAY;
      s_d.rdata = '0;
      case (s_axi_araddr[3:2])
        REG_CONTROL[3:2]:
        begin
          s_d.rdata[CTRL_FILT_LSB +: 2] = s_q.filt;
        end
        REG_STATUS[3:2]:
        begin
          s_d.rdata[STAT_CONTINUOUS] = s_q.continuous;
          s_d.rdata[STAT_STANDBY] = s_q.standby;
          s_d.rdata[STAT_POR_DONE] = s_q.por_done;
          s_d.rdata[STAT_CONV_RUN] = s_q.conv_run;
          s_d.rdata[STAT_READY_N] = s_q.ready_n;
          s_d.rdata[STAT_READ_PEND] = s_q.read_pend;
        end
        REG_RESULT[3:2]:
        begin
          s_d.rdata = s_q.result;
        end
        default:
        begin
          s_d.rresp = AXI_DECERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.rvalid;

    // Power-down: configuration back to defaults, conv_run drops so the modulator pin enables go low
    if (!power_down_n)
    begin
      s_d.filt = FILT_RESET;
      s_d.standby = 1'b0;
      s_d.continuous = 1'b1;
      s_d.read_pend = 1'b0;
      s_d.upd_cnt = '0;
    end
    // Internal reset held until the power-on count ends
    if (!s_q.por_done)
    begin
      s_d.continuous = 1'b1;
      s_d.standby = 1'b0;
      s_d.upd_cnt = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.filt <= FILT_RESET;
      s_q.continuous <= 1'b1;
      s_q.tx_cnt <= 6'(WORD_BITS);
      s_q.ready_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign conv_run = s_q.conv_run;
  assign dout = s_q.dout;
  assign result_ready_n = s_q.ready_n;
  assign modulator_bit_low_o = s_q.mod_bits[0];
  assign modulator_bit_high_o = s_q.mod_bits[1];
  assign mod_clk_o = s_q.mod_clk;
  assign modulator_bit_low_oe = s_q.mod_oe;
  assign modulator_bit_high_oe = s_q.mod_oe;
  assign mod_clk_oe = s_q.mod_oe;

endmodule : adsr_top

// file: test/adsr_top_assertions.sv
/*
  Checker for the converter readout block, bound to adsr_top.
  Assumes it sees only the top ports, one aclk domain, sync active-low reset.
*/
`timescale 1ns/10ps
module adsr_top_chk
  import adsr_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched pins
  input wire logic s_axi_bvalid,
  input wire logic power_down_n,
  input wire logic supplies_ok,
  input wire logic conv_run,
  input wire logic conv_valid,
  input wire logic sclk,
  input wire logic dout,
  input wire logic result_ready_n,
  input wire logic sync_in,
  input wire logic modulator_bit_low_oe,
  input wire logic modulator_bit_high_oe,
  input wire logic mod_clk_o,
  input wire logic mod_clk_oe
);
  // Saturates so a long supply-good run never wraps
  logic [16:0] sup_cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !supplies_ok)
      sup_cnt_q <= '0;
    else if (sup_cnt_q != '1)
      sup_cnt_q <= sup_cnt_q + 17'h1;
  end

  property p_reset_vals;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> result_ready_n && !dout && !conv_run && !s_axi_bvalid;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not idle after reset");

  property p_por;
    @(posedge aclk) disable iff (!aresetn) $rose(conv_run) |-> sup_cnt_q >= POR_CYCLES;
  endproperty
  a_por: assert property (p_por)
    else $error("converter started before power-on count");

  property p_power_down_n;
    @(posedge aclk) disable iff (!aresetn) !power_down_n |-> ##[1:2] (!conv_run && !mod_clk_oe);
  endproperty
  a_power_down_n: assert property (p_power_down_n)
    else $error("power-down did not stop converter");

  property p_upd;
    @(posedge aclk) disable iff (!aresetn) conv_valid && conv_run |=> result_ready_n [*4];
  endproperty
  a_upd: assert property (p_upd)
    else $error("ready not high for four clocks on update");

  property p_clr;
    @(posedge aclk) disable iff (!aresetn) !result_ready_n && $fell(sclk) |-> ##[1:3] result_ready_n;
  endproperty
  a_clr: assert property (p_clr)
    else $error("ready not cleared by serial clock fall");

  property p_oe;
    @(posedge aclk) disable iff (!aresetn) mod_clk_oe == modulator_bit_low_oe && mod_clk_oe == modulator_bit_high_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("modulator pin enables disagree");

  property p_sync;
    @(posedge aclk) disable iff (!aresetn) sync_in && !$past(sync_in) && mod_clk_oe |-> ##[5:6] $rose(mod_clk_o);
  endproperty
  a_sync: assert property (p_sync)
    else $error("modulator clock not restarted by sync");

  property p_period;
    @(posedge aclk) disable iff (!aresetn)
    (!sync_in) [*7] ##0 ($rose(mod_clk_o) && mod_clk_oe) ##1 (mod_clk_oe && !sync_in) [*4] |-> $rose(mod_clk_o);
  endproperty
  a_period: assert property (p_period)
    else $error("modulator clock period not four clocks");
endmodule : adsr_top_chk

bind adsr_top adsr_top_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);

// file: test/adsr_host.sv
/*
  Host serial controller model: shifts commands and reads results.
  Assumes sclk levels of four aclk periods, well within the sampling limit.
*/
`timescale 1ns/10ps
module adsr_host
(
  // Clock
  input wire logic aclk,
  // Serial pins
  input wire logic dout,
  output logic sclk,
  output logic din
);
  initial
  begin
    sclk = 1'h0;
    din = 1'h0;
  end

  task bx(input logic o, output logic r);
    @(posedge aclk);
    din <= o;
    repeat (3) @(posedge aclk);
    sclk <= 1'h1;
    r = dout;
    repeat (4) @(posedge aclk);
    sclk <= 1'h0;
  endtask : bx

  // Gap counted from the last fall, so sclk stays low for all of it
  task gap;
    @(posedge aclk);
    din <= 1'h0;
    repeat (24) @(posedge aclk);
  endtask : gap

  task cmd(input logic [7:0] c);
    logic r;
    for (int i = 7; i >= 0; i--)
      bx(c[i], r);
    gap;
  endtask : cmd

  task rd(input int n, output logic [31:0] v);
    logic b;
    v = '0;
    repeat (n)
    begin
      bx(1'h0, b);
      v = {v[30:0], b};
    end
    gap;
  endtask : rd
endmodule : adsr_host

// file: test/test_adsr_top.sv
/*
  Self-checking bench for adsr_top with the host model on the serial pins.
  Assumes 200 MHz aclk and a shortened power-on count.
*/
`timescale 1ns/10ps
module test_adsr_top
  import adsr_pkg::*;
;
  typedef struct packed {logic [1:0] f; logic [30:0] v; logic cp; logic cn; logic [31:0] e;} adsr_row_t;
  adsr_row_t rows [8] = '{'{2'h2, 31'h00000001, 1'h0, 1'h0, 32'h00000002},
    '{2'h2, 31'h7FFFFFFF, 1'h0, 1'h0, 32'hFFFFFFFF}, '{2'h2, 31'h3FFFFFFF, 1'h1, 1'h0, 32'h7FFFFFFF},
    '{2'h2, 31'h40000000, 1'h0, 1'h1, 32'h80000000}, '{2'h1, 31'h3FFFFFFF, 1'h0, 1'h0, 32'h3FFFFFFF},
    '{2'h1, 31'h40000000, 1'h0, 1'h0, 32'hC0000000}, '{2'h1, 31'h3FFFFFFF, 1'h1, 1'h0, 32'h3FFFFFFF},
    '{2'h3, 31'h7FFFFFFE, 1'h0, 1'h0, 32'hFFFFFFFD}};
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] r;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, power_down_n, supplies_ok, conv_run;
  logic conv_valid, conv_clip_pos, conv_clip_neg, sclk, din, dout, result_ready_n, sync_in;
  logic modulator_bit_low_o, modulator_bit_low_oe, modulator_bit_high_o, modulator_bit_high_oe, mod_clk_o, mod_clk_oe;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, mod_stream;
  logic [30:0] conv_value;

  adsr_top #(.POR_CYCLES(16)) uut (.*);
  adsr_host host (.*);

  always #2.5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    mod_stream <= mod_stream + 2'h1;
    if (cyc == 30000)
    begin
      n_fail++;
      wrap_up;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid)
      @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    while (!s_axi_rvalid)
      @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : axi_rd

  task conv(input logic [30:0] v, input logic cp, input logic cn);
    @(posedge aclk);
    conv_value <= v;
    conv_clip_pos <= cp;
    conv_clip_neg <= cn;
    conv_valid <= 1'h1;
    @(posedge aclk);
    conv_valid <= 1'h0;
  endtask : conv

  task wrdy;
    int k;
    k = 0;
    while (result_ready_n !== 1'h0 && k < 40)
    begin
      @(posedge aclk);
      k++;
    end
    chk(result_ready_n, 1'h0);
  endtask : wrdy

  task get(input logic [31:0] e);
    logic [31:0] x;
    wrdy;
    chk(dout, e[31]);
    host.rd(32, x);
    chk(x, e);
    chk(result_ready_n, 1'h1);
    // Whole byte of trailing clocks keeps the command bit count aligned
    host.rd(8, x);
    chk(x[7:0], 8'h00);
  endtask : get

  initial
  begin
    int k;
    k = 0;
    aclk = 1'h0;
    power_down_n = 1'h1;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
      s_axi_rready, conv_valid, conv_value, conv_clip_pos, conv_clip_neg, mod_stream, sync_in, supplies_ok,
      aresetn} = '0;
    repeat (4) @(posedge aclk);
    chk({result_ready_n, dout, conv_run}, 3'h4);
    aresetn <= 1'h1;
    supplies_ok <= 1'h1;
    while (conv_run !== 1'h1 && k < 60)
    begin
      @(posedge aclk);
      k++;
    end
    chk(k >= 16, 1'h1);
    axi_rd(REG_STATUS, 32'h1D, AXI_OKAY);
    axi_rd(REG_CONTROL, 32'h2, AXI_OKAY);
    axi_rd(4'hC, 32'h0, AXI_DECERR);
    axi_wr(4'hC, 32'h0, AXI_DECERR);
    foreach (rows[i])
    begin
      axi_wr(REG_CONTROL, {30'h0, rows[i].f}, AXI_OKAY);
      conv(rows[i].v, rows[i].cp, rows[i].cn);
      get(rows[i].e);
    end
    conv(31'h12345678, 1'h0, 1'h0);
    wrdy;
    conv(31'h12345678, 1'h0, 1'h0);
    repeat (2) @(posedge aclk);
    chk(result_ready_n, 1'h1);
    repeat (4) @(posedge aclk);
    chk(result_ready_n, 1'h0);
    host.rd(24, r);
    chk(r[23:0], 24'h2468AC);
    conv(31'h7EDCBA98, 1'h0, 1'h0);
    get(32'hFDB97531);
    host.cmd(OP_STOP_CONT);
    conv(rows[0].v, 1'h0, 1'h0);
    repeat (8) @(posedge aclk);
    chk(result_ready_n, 1'h1);
    host.cmd(OP_READ_ONE);
    conv(rows[1].v, 1'h0, 1'h0);
    repeat (8) @(posedge aclk);
    chk(result_ready_n, 1'h1);
    host.rd(32, r);
    chk(r, rows[1].e);
    host.cmd(OP_READ_ONE);
    conv(rows[0].v, 1'h0, 1'h0);
    repeat (8) @(posedge aclk);
    fork
      host.rd(32, r);
      begin
        repeat (60) @(posedge aclk);
        conv(rows[1].v, 1'h0, 1'h0);
      end
    join
    chk(r, rows[0].e);
    repeat (3) host.bx(1'h1, r[0]);
    repeat (65) conv(rows[0].v, 1'h0, 1'h0);
    host.cmd(OP_ENTER_CONT);
    conv(rows[0].v, 1'h0, 1'h0);
    get(rows[0].e);
    axi_wr(REG_CONTROL, 32'h1, AXI_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      host.cmd({OP_STBY_HI, i[0]});
      chk(conv_run, 1'h0);
      axi_rd(REG_CONTROL, 32'h1, AXI_OKAY);
      host.cmd({OP_WAKE_HI, ~i[0]});
      chk(conv_run, 1'h1);
      conv(rows[4].v, 1'h0, 1'h0);
      get(rows[4].e);
    end
    axi_wr(REG_CONTROL, 32'h0, AXI_OKAY);
    repeat (4) @(posedge aclk);
    chk({mod_clk_oe, modulator_bit_low_oe, modulator_bit_high_oe}, 3'h7);
    chk({modulator_bit_high_o, modulator_bit_low_o}, 2'(mod_stream - 2'h1));
    sync_in <= 1'h1;
    @(posedge aclk);
    sync_in <= 1'h0;
    repeat (20) @(posedge aclk);
    axi_wr(REG_CONTROL, 32'h2, AXI_OKAY);
    repeat (4) @(posedge aclk);
    chk(mod_clk_oe, 1'h0);
    axi_wr(REG_CONTROL, 32'h1, AXI_OKAY);
    power_down_n <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(conv_run, 1'h0);
    power_down_n <= 1'h1;
    axi_rd(REG_CONTROL, 32'h2, AXI_OKAY);
    wrap_up;
  end
endmodule : test_adsr_top
